//--- hdl/fpc_hiccup_timer.sv
// Restart interval timer counting while enabled
`timescale 1ns/1ps
module fpc_hiccup_timer
  import fpc_pkg::*;
#(
  parameter int LEN = HICCUP_CYCLES,
  localparam int W = $clog2(LEN + 1)
)(
  // Clock and reset
  input wire logic sys_clk,
  input wire logic rst_n,
  // Control and completion
  input wire logic run,
  output logic done
);
  typedef struct packed {
    logic [W-1:0] count;
    logic done;
  } fpc_tmr_s;

  fpc_tmr_s st_reg;
  fpc_tmr_s st_next;

  // Count restarts from zero whenever run drops, so each interval is whole
  always_comb
  begin
    st_next = st_reg;
    st_next.done = 1'b0;
    if (!run)
    begin
      st_next.count = '0;
    end
    else if (st_reg.count == W'(LEN - 1))
    begin
      st_next.count = '0;
      st_next.done = 1'b1;
    end
    else
    begin
      st_next.count = st_reg.count + W'(1);
    end
  end

  // State register
  always_ff @(posedge sys_clk)
  begin
    if (!rst_n)
      st_reg <= '0;
    else
      st_reg <= st_next;
  end

  assign done = st_reg.done;
endmodule

//--- hdl/fpc_link_if.sv
// Open-drain fault and error lines between converter modules and the manager
`timescale 1ns/1ps
interface fpc_link_if
  import fpc_pkg::*;
#(
  parameter int NG = NUM_GROUPS
);
  // Drive enables, high while the party pulls the line low
  logic devFaultOe [NG];
  logic devErrOe [NG];
  logic mgrFaultOe [NG];
  logic mgrErrOe [NG];
  // Resolved wired-AND levels, high when released
  logic faultLevel [NG];
  logic errLevel [NG];
  // Warning reports, active high
  logic tempReport [NG];
  logic pgoodReport [NG];

  // Resolve each open-drain wire from all enables
  for (genvar g = 0; g < NG; g++)
  begin : gResolve
    assign faultLevel[g] = ~(devFaultOe[g] | mgrFaultOe[g]);
    assign errLevel[g] = ~(devErrOe[g] | mgrErrOe[g]);
  end

  modport module_end (
    output devFaultOe,
    output devErrOe,
    output tempReport,
    output pgoodReport,
    input faultLevel,
    input errLevel
  );
  modport manager_end (
    output mgrFaultOe,
    output mgrErrOe,
    input faultLevel,
    input errLevel,
    input tempReport,
    input pgoodReport
  );
endinterface

//--- hdl/fpc_manager_end.sv
// Power manager end: carries faults and errors between groups
`timescale 1ns/1ps
module fpc_manager_end
  import fpc_pkg::*;
#(
  parameter int NG = NUM_GROUPS
)(
  // Clock and reset
  input wire logic sys_clk,
  input wire logic rst_n,
  // Group fault lines
  fpc_link_if.manager_end lnk,
  // Inter-group settings, bit src*NG+dst lets src shut down dst
  input wire logic [NG*NG-1:0] propMap,
  input wire logic frontEndEn,
  input wire logic crowbarEn,
  // System actions and observed status
  output logic frontEndOff,
  output logic crowbarFire,
  output logic [NG-1:0] groupFaultSeen,
  output logic [NG-1:0] tempWarnSeen,
  output logic [NG-1:0] pgoodWarnSeen
);
  typedef struct packed {
    logic [1:0][NG-1:0] fSync;
    logic [1:0][NG-1:0] eSync;
    logic [1:0][NG-1:0] tSync;
    logic [1:0][NG-1:0] pSync;
    logic [OWN_MASK_CYCLES-1:0][NG-1:0] hist;
    logic [NG-1:0] drvF;
    logic [NG-1:0] drvE;
    logic [NG-1:0] seen;
    logic anyErr;
    logic frontOff;
    logic crowbar;
  } fpc_mgr_s;

  fpc_mgr_s st_reg;
  fpc_mgr_s st_next;
  logic [NG-1:0] fLvl;
  logic [NG-1:0] eLvl;
  logic [NG-1:0] tLvl;
  logic [NG-1:0] pLvl;
  logic [NG-1:0] recent;
  logic [NG-1:0] src;
  logic [NG-1:0] srcErr;

  // Gather line levels and drive enables per group
  for (genvar g = 0; g < NG; g++)
  begin : gLine
    assign fLvl[g] = lnk.faultLevel[g];
    assign eLvl[g] = lnk.errLevel[g];
    assign tLvl[g] = lnk.tempReport[g];
    assign pLvl[g] = lnk.pgoodReport[g];
    assign lnk.mgrFaultOe[g] = st_reg.drvF[g];
    assign lnk.mgrErrOe[g] = st_reg.drvE[g];
  end

  // Next-state logic; own drive is masked so a pulled line is not a new source
  always_comb
  begin
    st_next = st_reg;
    recent = st_reg.drvF | st_reg.drvE;
    for (int k = 0; k < OWN_MASK_CYCLES; k++)
      recent = recent | st_reg.hist[k];
    st_next.hist = {st_reg.hist[OWN_MASK_CYCLES-2:0], st_reg.drvF | st_reg.drvE};
    st_next.fSync = {st_reg.fSync[0], fLvl};
    st_next.eSync = {st_reg.eSync[0], eLvl};
    st_next.tSync = {st_reg.tSync[0], tLvl};
    st_next.pSync = {st_reg.pSync[0], pLvl};
    src = ~st_reg.fSync[1] & ~recent;
    srcErr = src & ~st_reg.eSync[1];
    st_next.drvF = '0;
    st_next.drvE = '0;
    for (int s = 0; s < NG; s++)
    begin
      for (int d = 0; d < NG; d++)
      begin
        if (s != d && propMap[s*NG+d])
        begin
          st_next.drvF[d] = st_next.drvF[d] | src[s];
          st_next.drvE[d] = st_next.drvE[d] | srcErr[s];
        end
      end
    end
    st_next.seen = ~st_reg.fSync[1];
    // front end off and crowbar pulse
    st_next.anyErr = |srcErr;
    st_next.frontOff = (|srcErr) & frontEndEn;
    st_next.crowbar = (|srcErr) & !st_reg.anyErr & crowbarEn;
  end

  // State register; lines start released
  always_ff @(posedge sys_clk)
  begin
    if (!rst_n)
    begin
      st_reg <= '0;
      st_reg.fSync <= '1;
      st_reg.eSync <= '1;
    end
    else
    begin
      st_reg <= st_next;
    end
  end

  // Outputs from the state register
  assign frontEndOff = st_reg.frontOff;
  assign crowbarFire = st_reg.crowbar;
  assign groupFaultSeen = st_reg.seen;
  assign tempWarnSeen = st_reg.tSync[1];
  assign pgoodWarnSeen = st_reg.pSync[1];
endmodule

//--- hdl/fpc_module_end.sv
// Converter module end: fault detection response, propagation and hiccup restart
`timescale 1ns/1ps
// Summary of operation
// - A group holds one to thirty-two modules
// - Enabled detected fault pulls shared line low
// - Peer-held low line starts own turn-off
// - Bits 7,6 enable temperature, power good reports
// - Bit 5 enables tracking fault propagation
// - Bits 4..0 enable OT, OC, UV, OV, PV
// - Manager watches up to four groups
// - Manager pulls lines of chosen other groups
// - Error also turns front end off, crowbar
// - Propagated fault makes receivers turn off regularly
// - Detector turn-off speed follows fault type
// - Propagated error makes receivers turn off fast
// - Error detector turns off fast, low side on
// - Non-latching faults retry every 130 ms
// - Interval runs from zero output to ramp-up
// - Regular turn-off keeps delay and falling slew
// - Temperature warning monitored always, never turns off
// - Detectors armed only in their operating phase
// - Fast turn-off opens both switches at once
// - Regular turn-off ramps per sequencing settings
// - Latching protection stays off until released
module fpc_module_end
  import fpc_pkg::*;
#(
  parameter int GROUP_IDX = 0,
  parameter int HICCUP_LEN = HICCUP_CYCLES
)(
  // Clock and reset
  input wire logic sys_clk,
  input wire logic rst_n,
  // Shared fault link
  fpc_link_if.module_end lnk,
  // Configuration register port
  input wire logic cfgWrEn,
  input wire logic [CFG_W-1:0] cfgWrData,
  output logic [CFG_W-1:0] cfgRdData,
  // Control from the command and status logic
  input wire logic turnOnCmd,
  input wire logic statusClear,
  input wire logic [EVT_W-1:0] latchSel,
  // Output phase from the ramp controller
  input wire logic aboveBias,
  input wire logic rampingUp,
  input wire logic steadyState,
  input wire logic outputAtZero,
  // Detector events, active high
  input wire logic evtOverTemp,
  input wire logic evtOverCurr,
  input wire logic evtUnderVolt,
  input wire logic evtOverVolt,
  input wire logic evtPhaseVolt,
  input wire logic evtTracking,
  input wire logic tempWarnIn,
  input wire logic pgoodIn,
  // Power stage commands and status
  output logic runEn,
  output logic regularOff,
  output logic fastOff,
  output logic lowSideOn,
  output logic hiccupActive,
  output logic [EVT_W-1:0] faultCause
);
  typedef struct packed {
    fpc_dev_state_e state;
    logic [CFG_W-1:0] cfg;
    logic [EVT_W-1:0] cause;
    logic faultOe;
    logic errOe;
    logic tempRep;
    logic pgoodRep;
    logic runEn;
    logic regOff;
    logic fastOff;
    logic lowSide;
    logic hiccup;
    logic latchPending;
    logic [1:0] lineSync;
    logic [1:0] errSync;
    logic [OWN_MASK_CYCLES-1:0] ownHist;
  } fpc_dev_s;

  // Synchronisers start at the released level, so no false peer request follows reset
  localparam fpc_dev_s DEV_RESET = '{state: DEV_IDLE, cfg: CFG_RESET, lineSync: 2'b11,
    errSync: 2'b11, default: '0};

  fpc_dev_s st_reg;
  fpc_dev_s st_next;
  logic [EVT_W-1:0] evtVec;
  logic [EVT_W-1:0] armVec;
  logic [EVT_W-1:0] tripped;
  logic peerLow;
  logic peerErr;
  logic timerDone;

  // Hiccup interval, enabled only once the output has reached zero
  // interval from zero
  fpc_hiccup_timer #(
    .LEN(HICCUP_LEN)
  ) uTimer (
    .sys_clk(sys_clk),
    .rst_n(rst_n),
    .run(st_reg.state == DEV_HICCUP),
    .done(timerDone)
  );

  // Event and arming vectors share the configuration bit order
  always_comb
  begin
    evtVec = '0;
    armVec = '0;
    evtVec[TRACK_BIT] = evtTracking;
    evtVec[OVER_TEMP_BIT] = evtOverTemp;
    evtVec[OVER_CURR_BIT] = evtOverCurr;
    evtVec[UNDER_VOLT_BIT] = evtUnderVolt;
    evtVec[OVER_VOLT_BIT] = evtOverVolt;
    evtVec[PHASE_VOLT_BIT] = evtPhaseVolt;
    armVec[TRACK_BIT] = rampingUp;
    armVec[OVER_TEMP_BIT] = 1'b1;
    armVec[OVER_CURR_BIT] = aboveBias;
    armVec[UNDER_VOLT_BIT] = steadyState;
    armVec[OVER_VOLT_BIT] = aboveBias;
    armVec[PHASE_VOLT_BIT] = 1'b1;
  end

  // Trips only count while running; stray events while off are dropped
  assign tripped = evtVec & armVec & {EVT_W{st_reg.runEn}};
  assign peerLow = !st_reg.lineSync[1] && (st_reg.ownHist == '0);
  assign peerErr = !st_reg.errSync[1];

  // Next-state logic for the whole module end
  always_comb
  begin
    st_next = st_reg;
    st_next.lineSync = {st_reg.lineSync[0], lnk.faultLevel[GROUP_IDX]};
    st_next.errSync = {st_reg.errSync[0], lnk.errLevel[GROUP_IDX]};
    st_next.ownHist = {st_reg.ownHist[OWN_MASK_CYCLES-2:0], st_reg.faultOe | st_reg.errOe};
    if (cfgWrEn)
      st_next.cfg = cfgWrData;
    st_next.tempRep = st_reg.cfg[TEMP_REPORT_BIT] & tempWarnIn;
    st_next.pgoodRep = st_reg.cfg[PGOOD_REPORT_BIT] & steadyState & !pgoodIn;
    // Sticky cause bits: a new trip wins over a clear in the same cycle
    st_next.cause = (statusClear ? '0 : st_reg.cause) | tripped;
    case (st_reg.state)
      DEV_IDLE:
      begin
        st_next.runEn = turnOnCmd;
        if (turnOnCmd)
          st_next.state = DEV_RUN;
      end
      DEV_RUN:
      begin
        if (!turnOnCmd)
        begin
          st_next.runEn = 1'b0;
          st_next.state = DEV_IDLE;
        end
        else if (|tripped)
        begin
          st_next.runEn = 1'b0;
          st_next.faultOe = |(tripped & st_reg.cfg[EVT_W-1:0]);
          st_next.errOe = |(tripped & st_reg.cfg[EVT_W-1:0] & ERROR_MASK);
          st_next.latchPending = |(tripped & latchSel);
          if (|(tripped & ERROR_MASK))
          begin
            st_next.fastOff = 1'b1;
            st_next.lowSide = 1'b1;
            st_next.state = DEV_FAST_OFF;
          end
          else if (|(tripped & OWN_FAST_MASK))
          begin
            st_next.fastOff = 1'b1;
            st_next.state = DEV_FAST_OFF;
          end
          else
          begin
            st_next.regOff = 1'b1;
            st_next.state = DEV_RAMP_DOWN;
          end
        end
        else if (peerLow)
        begin
          st_next.runEn = 1'b0;
          st_next.latchPending = 1'b0;
          if (peerErr)
          begin
            st_next.fastOff = 1'b1;
            st_next.state = DEV_FAST_OFF;
          end
          else
          begin
            st_next.regOff = 1'b1;
            st_next.state = DEV_RAMP_DOWN;
          end
        end
      end
      DEV_RAMP_DOWN, DEV_FAST_OFF:
      begin
        if (outputAtZero)
        begin
          st_next.regOff = 1'b0;
          st_next.state = st_reg.latchPending ? DEV_LATCHED : DEV_HICCUP;
        end
      end
      DEV_HICCUP:
      begin
        if (timerDone)
        begin
          st_next.faultOe = 1'b0;
          st_next.errOe = 1'b0;
          st_next.fastOff = 1'b0;
          st_next.lowSide = 1'b0;
          st_next.runEn = turnOnCmd;
          st_next.state = turnOnCmd ? DEV_RUN : DEV_IDLE;
        end
      end
      DEV_LATCHED:
      begin
        // released by clear or turn-on cycle
        if (statusClear || !turnOnCmd)
        begin
          st_next.latchPending = 1'b0;
          st_next.state = DEV_HICCUP;
        end
      end
      default:
      begin
        st_next = DEV_RESET;
      end
    endcase
    st_next.hiccup = (st_next.state == DEV_HICCUP);
  end

  // State register
  always_ff @(posedge sys_clk)
  begin
    if (!rst_n)
      st_reg <= DEV_RESET;
    else
      st_reg <= st_next;
  end

  // Open-drain enables and reports onto this module's group line
  // shared line, drive low only
  assign lnk.devFaultOe[GROUP_IDX] = st_reg.faultOe;
  assign lnk.devErrOe[GROUP_IDX] = st_reg.errOe;
  assign lnk.tempReport[GROUP_IDX] = st_reg.tempRep;
  assign lnk.pgoodReport[GROUP_IDX] = st_reg.pgoodRep;

  // User side outputs, all from the state register
  assign cfgRdData = st_reg.cfg;
  assign runEn = st_reg.runEn;
  assign regularOff = st_reg.regOff;
  assign fastOff = st_reg.fastOff;
  assign lowSideOn = st_reg.lowSide;
  assign hiccupActive = st_reg.hiccup;
  assign faultCause = st_reg.cause;
endmodule

//--- hdl/fpc_pkg.sv
// Shared constants and types for the fault propagation control ends
package fpc_pkg;
  // Group structure
  localparam int NUM_GROUPS = 4;
  localparam int MAX_GROUP_SIZE = 32;
  // Clock rate and hiccup timing
  localparam int CLK_HZ = 40_000_000;
  localparam int HICCUP_MS = 130;
  localparam int HICCUP_CYCLES = HICCUP_MS * (CLK_HZ / 1000);
  // Cycles of own drive during which the line echo is ignored
  localparam int OWN_MASK_CYCLES = 4;
  // Configuration register layout
  localparam int CFG_W = 8;
  localparam int EVT_W = 6;
  localparam int TEMP_REPORT_BIT = 7;
  localparam int PGOOD_REPORT_BIT = 6;
  localparam int TRACK_BIT = 5;
  localparam int OVER_TEMP_BIT = 4;
  localparam int OVER_CURR_BIT = 3;
  localparam int UNDER_VOLT_BIT = 2;
  localparam int OVER_VOLT_BIT = 1;
  localparam int PHASE_VOLT_BIT = 0;
  localparam logic [CFG_W-1:0] CFG_RESET = 8'h3f;
  // Event classes, indexed like the configuration bits 5..0
  localparam logic [EVT_W-1:0] ERROR_MASK = 6'h03;
  localparam logic [EVT_W-1:0] OWN_FAST_MASK = 6'h28;
  // Module end sequencing states
  typedef enum logic [2:0] {
    DEV_IDLE,
    DEV_RUN,
    DEV_RAMP_DOWN,
    DEV_FAST_OFF,
    DEV_HICCUP,
    DEV_LATCHED
  } fpc_dev_state_e;
endpackage

//--- verif/fault_propagation_control_tb.sv
// Bench joining two converter ends and the manager over one link
`timescale 1ns/1ps
module fault_propagation_control_tb;
  import fpc_pkg::*;
  // Short hiccup keeps the run brief
  localparam int HL = 20;
  localparam logic [15:0] MAP = 16'h0002;
  logic sys_clk = 1'b0;
  logic rst_n = 1'b0;
  logic arm = 1'b1;
  logic az = 1'b0;
  logic pg = 1'b0;
  logic wrEn [2] = '{1'b0, 1'b0};
  logic on [2] = '{1'b0, 1'b0};
  logic tw [2] = '{1'b0, 1'b0};
  logic [7:0] wd [2] = '{8'h00, 8'h00};
  logic [5:0] ev [2] = '{6'h00, 6'h00};
  logic clr [2] = '{1'b0, 1'b0};
  logic [5:0] ls [2] = '{6'h00, 6'h00};
  logic run [2], rOff [2], fOff [2], lso [2], hic [2];
  logic [7:0] rd [2];
  logic [5:0] cause [2];
  logic feOff, cbFire;
  logic [3:0] twSeen, gSeen, pgSeen;
  int n_errors = 0;
  int comparisons = 0;
  int cyc = 0;
  int nCrow = 0;

  fpc_link_if #(.NG(4)) u_fpc_link_if ();
  // Groups 2 and 3 hold no module, their lines stay released
  for (genvar g = 2; g < 4; g++)
  begin : gIdle
    assign u_fpc_link_if.devFaultOe[g] = 1'b0;
    assign u_fpc_link_if.devErrOe[g] = 1'b0;
    assign u_fpc_link_if.tempReport[g] = 1'b0;
    assign u_fpc_link_if.pgoodReport[g] = 1'b0;
  end
  // One module end in each of groups 0 and 1
  for (genvar i = 0; i < 2; i++)
  begin : gEnd
    fpc_module_end #(.GROUP_IDX(i), .HICCUP_LEN(HL)) u_fpc_module_end (
      .sys_clk(sys_clk), .rst_n(rst_n), .lnk(u_fpc_link_if.module_end),
      .cfgWrEn(wrEn[i]), .cfgWrData(wd[i]), .cfgRdData(rd[i]),
      .turnOnCmd(on[i]), .statusClear(clr[i]), .latchSel(ls[i]),
      .aboveBias(arm), .rampingUp(arm), .steadyState(arm), .outputAtZero(az),
      .evtOverTemp(ev[i][4]), .evtOverCurr(ev[i][3]), .evtUnderVolt(ev[i][2]),
      .evtOverVolt(ev[i][1]), .evtPhaseVolt(ev[i][0]), .evtTracking(ev[i][5]),
      .tempWarnIn(tw[i]), .pgoodIn(pg), .runEn(run[i]), .regularOff(rOff[i]),
      .fastOff(fOff[i]), .lowSideOn(lso[i]), .hiccupActive(hic[i]),
      .faultCause(cause[i]));
  end
  fpc_manager_end #(.NG(4)) u_fpc_manager_end (
    .sys_clk(sys_clk), .rst_n(rst_n), .lnk(u_fpc_link_if.manager_end), .propMap(MAP),
    .frontEndEn(1'b1), .crowbarEn(1'b1), .frontEndOff(feOff), .crowbarFire(cbFire),
    .groupFaultSeen(gSeen), .tempWarnSeen(twSeen), .pgoodWarnSeen(pgSeen));
  fpc_checker #(.NG(4), .MAP(MAP)) u_fpc_checker (
    .sys_clk(sys_clk), .rst_n(rst_n), .devFaultOe(u_fpc_link_if.devFaultOe),
    .devErrOe(u_fpc_link_if.devErrOe), .mgrFaultOe(u_fpc_link_if.mgrFaultOe),
    .mgrErrOe(u_fpc_link_if.mgrErrOe), .faultLevel(u_fpc_link_if.faultLevel),
    .errLevel(u_fpc_link_if.errLevel), .tempReport(u_fpc_link_if.tempReport));

  // Clock at 40 MHz
  always #12.5 sys_clk = ~sys_clk;
  // Hang guard, crowbar pulse count
  always @(posedge sys_clk)
  begin
    cyc <= cyc + 1;
    nCrow <= nCrow + int'(cbFire);
    if (cyc == 5000)
    begin
      n_errors++;
      summarize();
    end
  end

  task automatic summarize();
    $display("comparisons %0d n_errors %0d", comparisons, n_errors);
    if (n_errors == 0 && comparisons > 0)
      $display("Result: passed");
    else
      $display("Result: failed");
    $finish;
  endtask
  task automatic chk(input string n, input logic [7:0] e, input logic [7:0] g);
    comparisons++;
    if (g !== e)
    begin
      n_errors++;
      $display("mismatch %s expected %h seen %h", n, e, g);
    end
  endtask
  task automatic tick(input int n);
    repeat (n) @(negedge sys_clk);
  endtask
  // Config write: taken at the rising edge, visible right after it, read back one cycle later
  task automatic wcfg(input int i, input logic [7:0] d);
    wrEn[i] = 1'b1;
    wd[i] = d;
    tick(1);
    wrEn[i] = 1'b0;
    tick(1);
    chk("cfg", d, rd[i]); // readback
  endtask

  initial
  begin
    int e, k;
    bit en, er, fs;
    tick(5);
    rst_n = 1'b1;
    tick(1);
    chk("cfgReset", 8'h3f, rd[0]); // reset value
    tick(3);
    on = '{1'b1, 1'b1};
    tick(2);
    wcfg(0, 8'hc0);
    wcfg(1, 8'h7f);
    tw[0] = 1'b1;
    tick(4);
    chk("tempRep", 1, u_fpc_link_if.tempReport[0]); // temp report
    chk("pgoodRep", 1, u_fpc_link_if.pgoodReport[1]); // pgood report
    chk("tempSeen", 1, twSeen[0]); // warning reaches manager
    chk("pgoodSeen", 1, pgSeen[1]); // pgood reaches manager
    chk("warnRun", 1, run[0]); // no turn-off
    tw[0] = 1'b0;
    // Every event, propagation enabled then disabled
    for (int p = 0; p < 12; p++)
    begin
      e = p % 6;
      en = p < 6;
      er = e < 2;
      fs = er || e == 3 || e == 5;
      wcfg(0, en ? 8'h3f : 8'h3f & ~(8'h01 << e));
      // Clear lands with the trip: old bits go, the new bit must survive
      ev[0][e] = 1'b1;
      clr[0] = 1'b1;
      tick(1);
      ev[0] = 6'h00;
      clr[0] = 1'b0;
      chk("cause", 8'(1 << e), {2'b00, cause[0]}); // event bits
      chk("faultOe", en, u_fpc_link_if.devFaultOe[0]); // line drive
      chk("errOe", en && er, u_fpc_link_if.devErrOe[0]); // error line
      chk("fastOff", fs, fOff[0]); // own speed
      chk("regOff", !fs, rOff[0]); // own speed
      chk("lowSide", er, lso[0]); // low side on
      tick(8);
      chk("rcvFast", en && er, fOff[1]); // receiver fast
      chk("rcvReg", en && !er, rOff[1]); // receiver regular
      chk("rcvRun", !en, run[1]); // receiver off
      chk("frontOff", en && er, feOff); // front end off
      chk("seen", en ? 8'h03 : 8'h00, {4'h0, gSeen}); // lines watched
      az = 1'b1;
      on[1] = 1'b0;
      tick(1);
      az = 1'b0;
      chk("hiccup", 1, hic[0]); // hiccup entry
      k = 0;
      while (run[0] !== 1'b1 && k < 100)
      begin
        tick(1);
        k++;
      end
      chk("interval", 8'(HL + 1), 8'(k)); // interval
      tick(6);
      on[1] = 1'b1;
      tick(3);
    end
    chk("crowbar", 2, 8'(nCrow)); // crowbar pulses
    // Latching undervoltage waits for a status clear before any retry
    ls[0] = 6'h04;
    ev[0] = 6'h04;
    tick(1);
    ev[0] = 6'h00;
    tick(8);
    az = 1'b1;
    tick(1);
    az = 1'b0;
    tick(HL + 10);
    chk("latchHic", 0, hic[0]); // no retry while latched
    chk("latchRun", 0, run[0]); // stays off
    chk("latchLine", 1, u_fpc_link_if.devFaultOe[0]); // line held
    clr[0] = 1'b1;
    tick(1);
    clr[0] = 1'b0;
    chk("clrCause", 0, {2'b00, cause[0]}); // status cleared
    chk("release", 1, hic[0]); // clear starts interval
    tick(HL);
    chk("relWait", 0, run[0]); // full interval
    tick(1);
    chk("relRun", 1, run[0]); // restart
    summarize();
  end
endmodule

//--- verif/fpc_checker.sv
// Interface checker for the group fault lines and the manager drive
`timescale 1ns/1ps
module fpc_checker
  import fpc_pkg::*;
#(
  parameter int NG = NUM_GROUPS,
  parameter logic [NG*NG-1:0] MAP = 16'h0002
)(
  // Clock and reset
  input wire logic sys_clk,
  input wire logic rst_n,
  // Drive enables of both ends
  input wire logic devFaultOe [NG],
  input wire logic devErrOe [NG],
  input wire logic mgrFaultOe [NG],
  input wire logic mgrErrOe [NG],
  // Resolved line levels and reports
  input wire logic faultLevel [NG],
  input wire logic errLevel [NG],
  input wire logic tempReport [NG]
);
  // Single clock domain, so one default clock and reset serve all
  default clocking cb @(posedge sys_clk);
  endclocking
  default disable iff (!rst_n);

  // Manager forwards group 0 to group 1 after sync plus one
  property p_fwd_fault;
    MAP[1] && $fell(faultLevel[0]) |-> ##3 mgrFaultOe[1];
  endproperty
  a_fwd_fault: assert property (p_fwd_fault) // forward
    else $error("manager did not forward fault to group 1");
  property p_fwd_release;
    MAP[1] && $rose(faultLevel[0]) |-> ##3 !mgrFaultOe[1];
  endproperty
  a_fwd_release: assert property (p_fwd_release) // release
    else $error("manager kept group 1 low after release");
  // Errors travel on both lines so receivers turn off fast
  property p_fwd_err;
    MAP[1] && $fell(errLevel[0]) |-> ##3 (mgrErrOe[1] && mgrFaultOe[1]);
  endproperty
  a_fwd_err: assert property (p_fwd_err) // forward
    else $error("manager did not forward error to group 1");
  property p_err_release;
    MAP[1] && $rose(errLevel[0]) |-> ##3 !mgrErrOe[1];
  endproperty
  a_err_release: assert property (p_err_release) // release
    else $error("manager kept error on group 1");
  // A forward drive always has a low source behind it
  property p_no_spurious;
    $rose(mgrFaultOe[1]) |-> $past(faultLevel[0], 3) == 1'b0;
  endproperty
  a_no_spurious: assert property (p_no_spurious) // cause
    else $error("manager drove group 1 with no source low");
  // No map bit targets group 0, so it is never pulled by the manager
  property p_no_dest0;
    (MAP & 16'h1111) == 16'h0000 |-> !mgrFaultOe[0] && !mgrErrOe[0];
  endproperty
  a_no_dest0: assert property (p_no_dest0) // chosen
    else $error("manager drove an unselected group");
  property p_err_with_fault;
    devErrOe[0] |-> devFaultOe[0];
  endproperty
  a_err_with_fault: assert property (p_err_with_fault) // line
    else $error("error driven without fault line");
  // Line stays low for eight cycles after it is first driven
  property p_hold;
    $rose(devFaultOe[0]) |-> devFaultOe[0] [*8];
  endproperty
  a_hold: assert property (p_hold) // hold
    else $error("fault line released too early");

  // Main scenarios reached
  c_fault: cover property ($fell(faultLevel[0]));
  c_err: cover property ($fell(errLevel[0]));
  c_temp: cover property ($rose(tempReport[0]));
endmodule
